//--- rtl/pwm_seq_pkg.sv
package pwm_seq_pkg;

  // ----------------------------------------------------------------
  // Sizes and register map
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH     = 3;
  localparam int unsigned PROG_DEPTH = 64;
  localparam logic [7:0]  ADDR_CTRL_STATUS = 8'h30;
  localparam logic [7:0]  ADDR_LOAD_BASE   = 8'h38;
  localparam int unsigned RUN_LSB    = 0;
  localparam int unsigned BAD_LSB    = 3;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [7:0]  LOAD_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ      = 200_000_000;
  localparam int unsigned STEP_TICK_HZ    = 2_000;
  localparam int unsigned TICK_CYCLES_DEF = SYS_CLK_HZ / STEP_TICK_HZ;
  localparam int unsigned PRESCALE_SHIFT  = 5;
  localparam logic [7:0]  PWM_PHASE_LAST  = 8'hfe;

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int unsigned OPC_HI = 15;
  localparam int unsigned OPC_LO = 13;
  localparam logic [2:0]  OPC_BRANCH  = 3'h5;
  localparam logic [2:0]  OPC_END     = 3'h6;
  localparam logic [2:0]  OPC_TRIGGER = 3'h7;
  localparam int unsigned PRESCALE_BIT = 14;
  localparam int unsigned STEP_HI  = 13;
  localparam int unsigned STEP_LO  = 8;
  localparam int unsigned SIGN_BIT = 7;
  localparam int unsigned INCR_HI  = 6;
  localparam int unsigned INCR_LO  = 0;
  localparam logic [6:0]  INCR_FULL = 7'h7f;
  localparam int unsigned BR_SEL_HI  = 12;
  localparam int unsigned BR_SEL_LO  = 11;
  localparam int unsigned BR_CNT_HI  = 10;
  localparam int unsigned BR_CNT_LO  = 7;
  localparam int unsigned BR_REL_BIT = 6;
  localparam int unsigned BR_ADR_HI  = 5;
  localparam int unsigned BR_ADR_LO  = 0;
  localparam int unsigned TRIGGER_CMD_WAIT_HI = 12;
  localparam int unsigned TRIGGER_CMD_WAIT_LO = 10;
  localparam int unsigned TRIGGER_CMD_SEND_HI = 9;
  localparam int unsigned TRIGGER_CMD_SEND_LO = 7;
  localparam logic [7:0]  LEVEL_MAX   = 8'hff;
  localparam logic [7:0]  LEVEL_MIN   = 8'h00;
  localparam logic [7:0]  LEVEL_RESET = 8'hff;

  typedef enum logic [2:0] {
    CMD_RAMP       = 3'b000,
    CMD_SET_MAX    = 3'b001,
    CMD_SET_MIN    = 3'b010,
    CMD_GOTO_START = 3'b011,
    CMD_BRANCH     = 3'b100,
    CMD_END        = 3'b101,
    CMD_TRIGGER    = 3'b110,
    CMD_BAD        = 3'b111
  } cmd_t;

  typedef enum logic [1:0] {
    ST_HALT      = 2'b00,
    ST_RUN       = 2'b01,
    ST_RAMP      = 2'b10,
    ST_TRIGGER_CMD_WAIT = 2'b11
  } seq_state_t;

  function automatic cmd_t decode_cmd(input logic [15:0] ins);
    cmd_t c;
    c = CMD_BAD;
    if (ins[OPC_HI] == 1'b0) begin
      if (ins[STEP_HI:STEP_LO] != 6'h00) begin
        if (ins[INCR_HI:INCR_LO] != 7'h00) begin
          c = CMD_RAMP;
        end
      end else if (ins[INCR_HI:INCR_LO] == INCR_FULL) begin
        c = ins[SIGN_BIT] ? CMD_SET_MIN : CMD_SET_MAX;
      end else if (ins[14:0] == 15'h0000) begin
        c = CMD_GOTO_START;
      end
    end else begin
      unique case (ins[OPC_HI:OPC_LO])
        OPC_BRANCH:  c = CMD_BRANCH;
        OPC_END:     c = CMD_END;
        OPC_TRIGGER: c = CMD_TRIGGER;
        default:     c = CMD_BAD;
      endcase
    end
    return c;
  endfunction

  function automatic logic [10:0] ramp_reload(input logic [15:0] ins);
    logic [10:0] t;
    t = {5'h00, ins[STEP_HI:STEP_LO]};
    if (ins[PRESCALE_BIT]) begin
      t = t << PRESCALE_SHIFT;
    end
    return t - 11'h001;
  endfunction

endpackage

//--- rtl/prog_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface prog_mem_if;
  import pwm_seq_pkg::*;
  logic        wr_en;
  logic [1:0]  wr_ch;
  logic [5:0]  wr_idx;
  logic [15:0] wr_data;
  logic [NUM_CH-1:0][5:0]  rd_idx;
  logic [NUM_CH-1:0][15:0] rd_data;
  modport store (input wr_en, wr_ch, wr_idx, wr_data, rd_idx,
                 output rd_data);
  modport user  (output wr_en, wr_ch, wr_idx, wr_data, rd_idx,
                 input rd_data);
endinterface
`default_nettype wire

//--- rtl/prog_mem.sv
`timescale 1ns/1ps
`default_nettype none
module prog_mem
  import pwm_seq_pkg::*;
(
  input wire logic       clk_sys,
  prog_mem_if.store      mp
);
  // No reset: program storage only, never read before loading
  logic [15:0] mem_q [NUM_CH][PROG_DEPTH];

  always_ff @(posedge clk_sys) begin
    if (mp.wr_en) begin
      mem_q[mp.wr_ch][mp.wr_idx] <= mp.wr_data;
    end
  end

  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      mp.rd_data[ch] = mem_q[ch][mp.rd_idx[ch]];
    end
  end
endmodule
`default_nettype wire

//--- rtl/pwm_out_gen.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_out_gen
  import pwm_seq_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic [NUM_CH-1:0][7:0] level,
  output logic      [NUM_CH-1:0]      pwm_q
);
  logic [7:0] phase_q;

  // Phase stops one short of full scale so 0xff stays low throughout
  always_ff @(posedge clk_sys) begin
    if (reset || phase_q == PWM_PHASE_LAST) begin
      phase_q <= 8'h00;
    end else begin
      phase_q <= phase_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (reset) begin
        pwm_q[ch] <= 1'b0;
      end else begin
        pwm_q[ch] <= (phase_q >= level[ch]);
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/led_pwm_sequencer_control.sv
`timescale 1ns/1ps
`default_nettype none
module led_pwm_sequencer_control
  import pwm_seq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr_en,
  input  wire logic              reg_rd_en,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata_q,
  output logic                   reg_rvalid_q,
  output logic      [NUM_CH-1:0] pwm_out_q,
  output logic      [NUM_CH-1:0] end_irq_q
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

  prog_mem_if mp ();

  logic [16:0]             tick_cnt_q;
  logic                    tick_q;
  logic [NUM_CH-1:0]       run_q;
  logic [NUM_CH-1:0]       bad_q;
  logic [NUM_CH-1:0][5:0]  load_ptr_q;
  logic [NUM_CH-1:0]       low_next_q;
  logic [NUM_CH-1:0][7:0]  hold_q;
  seq_state_t              st_q        [NUM_CH];
  logic [NUM_CH-1:0][5:0]  pc_q;
  logic [NUM_CH-1:0][7:0]  level_q;
  logic [NUM_CH-1:0][15:0] ramp_ins_q;
  logic [NUM_CH-1:0][10:0] ramp_wait_q;
  logic [NUM_CH-1:0][6:0]  ramp_left_q;
  logic [NUM_CH-1:0][3:0]  loop_armed_q;
  logic [3:0]              loop_ctr_q  [NUM_CH][4];
  logic [NUM_CH-1:0][2:0]  wait_mask_q;
  logic [NUM_CH-1:0][2:0]  trigger_cmd_pend_q;

  logic                    ctrl_wr;
  logic [NUM_CH-1:0]       load_hit;
  cmd_t                    cmd         [NUM_CH];
  logic [NUM_CH-1:0][15:0] ins;
  logic [NUM_CH-1:0]       exec;
  logic [NUM_CH-1:0]       end_evt;
  logic [NUM_CH-1:0]       bad_evt;
  logic [NUM_CH-1:0]       chan_stop;
  logic [NUM_CH-1:0]       trigger_cmd_ok;
  logic [NUM_CH-1:0][2:0]  trigger_cmd_set;
  logic [NUM_CH-1:0][2:0]  trigger_cmd_take;

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  prog_mem u_prog_mem (
    .clk_sys (clk_sys),
    .mp      (mp.store)
  );

  pwm_out_gen u_pwm_out_gen (
    .clk_sys (clk_sys),
    .reset   (reset),
    .level   (level_q),
    .pwm_q   (pwm_out_q)
  );

  // ----------------------------------------------------------------
  // Step time base
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset || tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= 17'h00000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 17'h00001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_LAST);
    end
  end

  // ----------------------------------------------------------------
  // Decode and events
  // ----------------------------------------------------------------
  assign ctrl_wr = reg_wr_en && reg_addr == ADDR_CTRL_STATUS;

  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      load_hit[ch] = (reg_addr == ADDR_LOAD_BASE + 8'(ch));
      ins[ch]      = mp.rd_data[ch];
      cmd[ch]      = decode_cmd(ins[ch]);
      exec[ch]     = (st_q[ch] == ST_RUN);
      end_evt[ch]  = exec[ch] && cmd[ch] == CMD_END;
      bad_evt[ch]  = exec[ch] && cmd[ch] == CMD_BAD;
      chan_stop[ch] = run_q[ch] &&
                      (end_evt[ch] || bad_evt[ch] ||
                       (ctrl_wr && !reg_wdata[RUN_LSB + ch]));
      trigger_cmd_ok[ch]  = (trigger_cmd_pend_q[ch] & wait_mask_q[ch]) == wait_mask_q[ch];
      trigger_cmd_take[ch] = (st_q[ch] == ST_TRIGGER_CMD_WAIT && trigger_cmd_ok[ch]) ?
                      wait_mask_q[ch] : 3'h0;
    end
    // Bit src of a channel's pending set means src has signalled it
    for (int dst = 0; dst < NUM_CH; dst++) begin
      for (int src = 0; src < NUM_CH; src++) begin
        trigger_cmd_set[dst][src] = exec[src] && cmd[src] == CMD_TRIGGER &&
                             ins[src][TRIGGER_CMD_SEND_LO + dst];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and status register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      run_q <= CTRL_RESET[RUN_LSB +: NUM_CH];
      bad_q <= CTRL_RESET[BAD_LSB +: NUM_CH];
    end else begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        // Hardware stop beats a simultaneous software start
        if (end_evt[ch] || bad_evt[ch]) begin
          run_q[ch] <= 1'b0;
        end else if (ctrl_wr) begin
          run_q[ch] <= reg_wdata[RUN_LSB + ch];
        end
        if (bad_evt[ch]) begin
          bad_q[ch] <= 1'b1;
        end else if (ctrl_wr && reg_wdata[RUN_LSB + ch]) begin
          bad_q[ch] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Load port: pointer, byte phase, memory write
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (reset || chan_stop[ch]) begin
        load_ptr_q[ch] <= 6'h00;
        low_next_q[ch] <= 1'b0;
        hold_q[ch]     <= LOAD_RESET;
      end else if (!run_q[ch] && load_hit[ch] &&
                   (reg_wr_en || reg_rd_en)) begin
        // One shared phase: reads and writes advance the same pointer
        low_next_q[ch] <= !low_next_q[ch];
        if (reg_wr_en && !low_next_q[ch]) begin
          hold_q[ch] <= reg_wdata;
        end
        if (low_next_q[ch]) begin
          load_ptr_q[ch] <= load_ptr_q[ch] + 6'h01;
        end
      end
    end
  end

  always_comb begin
    mp.wr_en   = 1'b0;
    mp.wr_ch   = 2'h0;
    mp.wr_idx  = 6'h00;
    mp.wr_data = 16'h0000;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      mp.rd_idx[ch] = run_q[ch] ? pc_q[ch] : load_ptr_q[ch];
      if (reg_wr_en && load_hit[ch] && !run_q[ch] && low_next_q[ch]) begin
        mp.wr_en   = 1'b1;
        mp.wr_ch   = 2'(ch);
        mp.wr_idx  = load_ptr_q[ch];
        mp.wr_data = {hold_q[ch], reg_wdata};
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd_en && !reg_wr_en;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd_en && !reg_wr_en) begin
      reg_rdata_q <= 8'h00;
      if (reg_addr == ADDR_CTRL_STATUS) begin
        reg_rdata_q <= {2'b00, bad_q, run_q};
      end
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (load_hit[ch] && !run_q[ch]) begin
          reg_rdata_q <= low_next_q[ch] ? mp.rd_data[ch][7:0]
                                        : mp.rd_data[ch][15:8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // End request toward the host
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      end_irq_q <= '0;
    end else begin
      end_irq_q <= end_evt;
    end
  end

  // ----------------------------------------------------------------
  // Trigger pending flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (reset || !run_q[ch]) begin
        trigger_cmd_pend_q[ch] <= 3'h0;
      end else begin
        // A new trigger wins over consuming an old one
        trigger_cmd_pend_q[ch] <= (trigger_cmd_pend_q[ch] & ~trigger_cmd_take[ch]) |
                           trigger_cmd_set[ch];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (reset || !run_q[ch] || chan_stop[ch]) begin
        st_q[ch]         <= ST_HALT;
        pc_q[ch]         <= 6'h00;
        level_q[ch]      <= LEVEL_RESET;
        ramp_ins_q[ch]   <= 16'h0000;
        ramp_wait_q[ch]  <= 11'h000;
        ramp_left_q[ch]  <= 7'h00;
        wait_mask_q[ch]  <= 3'h0;
        loop_armed_q[ch] <= 4'h0;
        for (int l = 0; l < 4; l++) begin
          loop_ctr_q[ch][l] <= 4'h0;
        end
      end else begin
        unique case (st_q[ch])
          ST_HALT: begin
            st_q[ch] <= ST_RUN;
          end
          ST_RUN: begin
            unique case (cmd[ch])
              CMD_RAMP: begin
                ramp_ins_q[ch]  <= ins[ch];
                ramp_wait_q[ch] <= ramp_reload(ins[ch]);
                ramp_left_q[ch] <= ins[ch][INCR_HI:INCR_LO];
                st_q[ch]        <= ST_RAMP;
              end
              CMD_SET_MAX: begin
                level_q[ch] <= LEVEL_MAX;
                pc_q[ch]    <= pc_q[ch] + 6'h01;
              end
              CMD_SET_MIN: begin
                level_q[ch] <= LEVEL_MIN;
                pc_q[ch]    <= pc_q[ch] + 6'h01;
              end
              CMD_GOTO_START: begin
                pc_q[ch] <= 6'h00;
              end
              CMD_BRANCH: begin
                if (ins[ch][BR_CNT_HI:BR_CNT_LO] == 4'h0) begin
                  pc_q[ch] <= br_target(pc_q[ch], ins[ch]);
                end else if (!loop_armed_q[ch][ins[ch][BR_SEL_HI:BR_SEL_LO]])
                begin
                  loop_armed_q[ch][ins[ch][BR_SEL_HI:BR_SEL_LO]] <= 1'b1;
                  loop_ctr_q[ch][ins[ch][BR_SEL_HI:BR_SEL_LO]] <=
                    ins[ch][BR_CNT_HI:BR_CNT_LO] - 4'h1;
                  pc_q[ch] <= br_target(pc_q[ch], ins[ch]);
                end else if (loop_ctr_q[ch][ins[ch][BR_SEL_HI:BR_SEL_LO]]
                             == 4'h0) begin
                  loop_armed_q[ch][ins[ch][BR_SEL_HI:BR_SEL_LO]] <= 1'b0;
                  pc_q[ch] <= pc_q[ch] + 6'h01;
                end else begin
                  loop_ctr_q[ch][ins[ch][BR_SEL_HI:BR_SEL_LO]] <=
                    loop_ctr_q[ch][ins[ch][BR_SEL_HI:BR_SEL_LO]] - 4'h1;
                  pc_q[ch] <= br_target(pc_q[ch], ins[ch]);
                end
              end
              CMD_TRIGGER: begin
                pc_q[ch] <= pc_q[ch] + 6'h01;
                if (ins[ch][TRIGGER_CMD_WAIT_HI:TRIGGER_CMD_WAIT_LO] != 3'h0) begin
                  wait_mask_q[ch] <= ins[ch][TRIGGER_CMD_WAIT_HI:TRIGGER_CMD_WAIT_LO];
                  st_q[ch]        <= ST_TRIGGER_CMD_WAIT;
                end
              end
              CMD_END, CMD_BAD: begin
                st_q[ch] <= ST_HALT;
              end
            endcase
          end
          ST_RAMP: begin
            // Ramp advances only on the slow step tick
            if (tick_q) begin
              if (ramp_wait_q[ch] == 11'h000) begin
                level_q[ch] <= step_level(level_q[ch],
                                          ramp_ins_q[ch][SIGN_BIT]);
                if (ramp_left_q[ch] == 7'h01) begin
                  st_q[ch] <= ST_RUN;
                  pc_q[ch] <= pc_q[ch] + 6'h01;
                end else begin
                  ramp_left_q[ch] <= ramp_left_q[ch] - 7'h01;
                  ramp_wait_q[ch] <= ramp_reload(ramp_ins_q[ch]);
                end
              end else begin
                ramp_wait_q[ch] <= ramp_wait_q[ch] - 11'h001;
              end
            end
          end
          ST_TRIGGER_CMD_WAIT: begin
            if (trigger_cmd_ok[ch]) begin
              st_q[ch] <= ST_RUN;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] br_target(input logic [5:0]  pc,
                                           input logic [15:0] i);
    // Relative jumps go backward by the offset, wrapping in 64 slots
    return i[BR_REL_BIT] ? pc - i[BR_ADR_HI:BR_ADR_LO]
                         : i[BR_ADR_HI:BR_ADR_LO];
  endfunction

  function automatic logic [7:0] step_level(input logic [7:0] lv,
                                            input logic       down);
    // Saturate so a long ramp never wraps the brightness
    if (down) begin
      return (lv == LEVEL_MIN) ? lv : lv - 8'h01;
    end
    return (lv == LEVEL_MAX) ? lv : lv + 8'h01;
  endfunction

endmodule
`default_nettype wire

//--- bench/pwm_seq_props.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_seq_props
  import pwm_seq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 4
)
(
  input wire logic              clk_sys,
  input wire logic              reset,
  input wire logic [7:0]        reg_addr,
  input wire logic              reg_wr_en,
  input wire logic              reg_rd_en,
  input wire logic [7:0]        reg_wdata,
  input wire logic [7:0]        reg_rdata_q,
  input wire logic              reg_rvalid_q,
  input wire logic [NUM_CH-1:0] pwm_out_q,
  input wire logic [NUM_CH-1:0] end_irq_q
);
  // ------
  // Bus and status
  // ------
  wire logic rd_only = reg_rd_en && !reg_wr_en;
  wire logic mapped = reg_addr == 8'h30 ||
                      (reg_addr >= 8'h38 && reg_addr <= 8'h3a);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_read_answered:
    assert property (rd_only |=> reg_rvalid_q) else $error("no answer");
  chk_answer_cause:
    assert property (reg_rvalid_q |-> $past(rd_only))
    else $error("stray answer");
  chk_write_silent:
    assert property (reg_wr_en |=> !reg_rvalid_q) else $error("write answered");
  chk_unmapped_zero:
    assert property (rd_only && !mapped |=> reg_rdata_q == 8'h00)
    else $error("unmapped data");
  chk_upper_zero:
    assert property (reg_rvalid_q && $past(reg_addr) == 8'h30
      |-> reg_rdata_q[7:6] == 2'b00) else $error("upper bits set");
  chk_run_or_flag:
    assert property (reg_rvalid_q && $past(reg_addr) == 8'h30
      |-> (reg_rdata_q[2:0] & reg_rdata_q[5:3]) == 3'h0)
    else $error("run and flag");
  chk_rdata_holds:
    assert property ($changed(reg_rdata_q) |-> reg_rvalid_q)
    else $error("data moved");
  chk_irq_pulse:
    assert property ((end_irq_q & $past(end_irq_q)) == 3'h0)
    else $error("irq too long");
endmodule
bind led_pwm_sequencer_control pwm_seq_props #(.TICK_CYCLES(TICK_CYCLES))
  pwm_seq_props_i (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
  .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
  .pwm_out_q(pwm_out_q), .end_irq_q(end_irq_q));
`default_nettype wire

//--- bench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk_sys,
  output logic      [7:0] reg_addr,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata_q,
  input  wire logic       reg_rvalid_q
);
  // ------
  // Byte transfers
  // ------
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    reg_wdata <= ~d; // Released data must not look valid
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hxx;
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    // Sample mid-cycle, clear of the edge that launches the answer
    for (int n = 0; n < 4; n++) begin
      @(negedge clk_sys);
      if (reg_rvalid_q === 1'b1) begin
        d = reg_rdata_q;
        break;
      end
    end
  endtask
  task automatic load(input logic [7:0] a, input logic [15:0] w);
    wr(a, w[15:8]);
    wr(a, w[7:0]);
  endtask
endmodule
`default_nettype wire

//--- bench/led_pwm_sequencer_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module led_pwm_sequencer_control_test
  import pwm_seq_pkg::*;
;
  localparam logic [15:0] W_SET_MIN_CMD = 16'h00ff;
  localparam logic [15:0] W_SET_MAX_CMD = 16'h007f;
  localparam logic [15:0] W_WAIT = 16'he800;
  localparam logic [15:0] W_SEND = 16'he080;
  localparam logic [15:0] W_END  = 16'hc000;
  localparam logic [15:0] W_RAMP = 16'h0103;
  localparam logic [15:0] W_LOOP = 16'ha100;
  logic              clk_sys;
  logic              reset;
  logic [7:0]        reg_addr;
  logic [7:0]        reg_wdata;
  logic [7:0]        reg_rdata_q;
  logic [7:0]        rv;
  logic              reg_wr_en;
  logic              reg_rd_en;
  logic              reg_rvalid_q;
  logic [NUM_CH-1:0] pwm_out_q;
  logic [NUM_CH-1:0] end_irq_q;
  logic [NUM_CH-1:0] seen;
  logic [15:0]       first;
  int                miscompares = 0;
  int                total_checks = 0;
  led_pwm_sequencer_control #(.TICK_CYCLES(4)) led_pwm_sequencer_control_i (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .pwm_out_q(pwm_out_q), .end_irq_q(end_irq_q));
  host_model host_model_i (.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q));
  // ------
  // Expectations and checks
  // ------
  function automatic logic [7:0] stat(logic [2:0] run, logic [2:0] bad);
    return {2'b00, bad, run};
  endfunction
  task automatic check(input string what, input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, e);
    host_model_i.rd(a, rv);
    check(what, rv, e);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ------
  // Sequence
  // ------
  initial begin
    reset = 1'b1;
    void'($urandom(92));
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk("status", ADDR_CTRL_STATUS, stat(3'h0, 3'h0));
    first = $urandom_range(1) ? W_SET_MIN_CMD : W_SET_MAX_CMD;
    host_model_i.load(8'h38, first);
    host_model_i.load(8'h38, W_WAIT);
    host_model_i.load(8'h38, W_END);
    host_model_i.load(8'h39, W_SEND);
    host_model_i.load(8'h39, W_END);
    host_model_i.wr(ADDR_CTRL_STATUS, 8'h01);
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    check("pwm0", {7'h00, pwm_out_q[0]}, {7'h00, first == W_SET_MIN_CMD});
    check("stalled", {5'h00, end_irq_q}, 8'h00);
    host_model_i.load(8'h38, 16'h1234);
    rd_chk("busy port", 8'h38, 8'h00);
    rd_chk("running", ADDR_CTRL_STATUS, stat(3'h1, 3'h0));
    host_model_i.wr(ADDR_CTRL_STATUS, 8'h03);
    seen = '0;
    // Channel 1 ends one cycle before channel 0, so gather both pulses
    repeat (40) begin
      @(negedge clk_sys);
      seen = seen | end_irq_q;
    end
    check("end irq", {5'h00, seen}, 8'h03);
    rd_chk("ended", ADDR_CTRL_STATUS, stat(3'h0, 3'h0));
    rd_chk("word hi", 8'h38, first[15:8]);
    rd_chk("word lo", 8'h38, first[7:0]);
    rd_chk("next hi", 8'h38, W_WAIT[15:8]);
    host_model_i.load(8'h3a, 16'h8000);
    host_model_i.wr(ADDR_CTRL_STATUS, 8'h04);
    repeat (10) @(posedge clk_sys);
    rd_chk("bad flag", ADDR_CTRL_STATUS, stat(3'h0, 3'h4));
    host_model_i.wr(ADDR_CTRL_STATUS, 8'hf8);
    rd_chk("flag ro", ADDR_CTRL_STATUS, stat(3'h0, 3'h4));
    host_model_i.wr(8'h3b, 8'($urandom));
    rd_chk("unmapped", 8'h3b, 8'h00);
    // Three passes of a three-count ramp: nine ticks before the end
    host_model_i.load(8'h39, W_RAMP);
    host_model_i.load(8'h39, W_LOOP);
    host_model_i.load(8'h39, W_END);
    host_model_i.wr(ADDR_CTRL_STATUS, 8'h02);
    seen = '0;
    repeat (26) begin
      @(negedge clk_sys);
      seen = seen | end_irq_q;
    end
    check("early end", {5'h00, seen}, 8'h00);
    repeat (60) begin
      @(negedge clk_sys);
      seen = seen | end_irq_q;
    end
    check("loop end", {5'h00, seen}, 8'h02);
    rd_chk("ramp hi", 8'h39, W_RAMP[15:8]);
    host_model_i.wr(ADDR_CTRL_STATUS, 8'h02);
    host_model_i.wr(ADDR_CTRL_STATUS, 8'h00);
    rd_chk("stopped", ADDR_CTRL_STATUS, stat(3'h0, 3'h4));
    rd_chk("phase reset", 8'h39, W_RAMP[15:8]);
    give_verdict();
  end
endmodule
`default_nettype wire
